/* File: flash_erase_suspend_powerdown.v */
/*
 * Serial flash command sequencer for erase, pause/resume and deep
 * power-down. Shifts opcode and address in on serial clock edges found
 * by the core clock, then runs self-timed cycles and keeps the status.
 * Assumes the host drives chip select and serial clock (SPI mode 0/3),
 * serial clock well under a quarter of clk_i, and nrst_i is power-on.
 */
`include "flash_seq_regs.vh"

// Behaviour
// - 20h plus address erases 4 KB block.
// - 52h plus address erases 32 KB block.
// - D8h plus address erases 64 KB block.
// - C7h or 60h erases whole array.
// - Select must rise after last eighth bit.
// - Select rise starts matching self-timed erase.
// - Busy high during cycle, status stays readable.
// - Busy start clears write enable latch.
// - Pause accepted only when busy, not paused.
// - Whole-array erase cannot be paused.
// - Pause sets flag now, busy drops within latency.
// - Resume accepted only when paused, not busy.
// - Resume clears flag, busy within 200ns.
// - Power loss clears pause, refuses resume.
// - B9h at byte boundary enters power-down.
// - Power-down obeys only the release opcode.
// - Power-up always starts in standby.
// - ABh releases power-down at once; commands wait out the release delay.
// - Write enable opcode sets the latch.
module flash_erase_suspend_powerdown
(
    input  wire        clk_i,
    input  wire        nrst_i,
    input  wire        ce_i,
    input  wire        cs_n_i,
    input  wire        sck_i,
    input  wire        si_i,
    input  wire        prog_start_i,
    output reg         busy_o,
    output reg         write_enable_latch_o,
    output reg         paused_op_flag_o,
    output reg         powered_down_o,
    output reg         erase_req_o,
    output reg  [23:0] erase_addr_o,
    output reg  [23:0] erase_mask_o,
    output wire [7:0]  erase_fill_o
);

    // ------------------------------------------------------------------
    // States (one-hot)
    // ------------------------------------------------------------------
    localparam [5:0] ST_IDLE   = 6'h01;
    localparam [5:0] ST_RUN    = 6'h02;
    localparam [5:0] ST_PAUSEW = 6'h04;
    localparam [5:0] ST_PAUSED = 6'h08;
    localparam [5:0] ST_RESW   = 6'h10;
    localparam [5:0] ST_PDN    = 6'h20;

    localparam [2:0] K_NONE = 3'd0;
    localparam [2:0] K_4K   = 3'd1;
    localparam [2:0] K_32K  = 3'd2;
    localparam [2:0] K_64K  = 3'd3;
    localparam [2:0] K_CHIP = 3'd4;
    localparam [2:0] K_PROG = 3'd5;

    wire        cs_n_s;
    wire        sck_s;
    wire        si_s;
    reg         sck_d_ff;
    reg         cs_d_ff;
    reg  [5:0]  bits_ff;
    reg  [7:0]  op_ff;
    reg  [23:0] addr_ff;
    reg  [5:0]  state_ff;
    reg  [2:0]  kind_ff;
    reg  [31:0] remain_ff;
    reg  [31:0] tmr_ff;
    reg         pdn_pend_ff;
    reg         wake_pend_ff;

    wire sck_rise = sck_s & ~sck_d_ff;
    wire cs_rise  = cs_n_s & ~cs_d_ff;
    wire cs_fall  = ~cs_n_s & cs_d_ff;
    wire [7:0] op_done = {op_ff[6:0], si_s};

    // Erased cells read all ones
    assign erase_fill_o = `ERASED_BYTE;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    pin_sync3 #(.RESET_VAL(1'b1)) u_cs
    (
        .clk_i   (clk_i),
        .nrst_i  (nrst_i),
        .ce_i    (ce_i),
        .pin_i   (cs_n_i),
        .level_o (cs_n_s)
    );

    pin_sync3 #(.RESET_VAL(1'b0)) u_sck
    (
        .clk_i   (clk_i),
        .nrst_i  (nrst_i),
        .ce_i    (ce_i),
        .pin_i   (sck_i),
        .level_o (sck_s)
    );

    pin_sync3 #(.RESET_VAL(1'b0)) u_si
    (
        .clk_i   (clk_i),
        .nrst_i  (nrst_i),
        .ce_i    (ce_i),
        .pin_i   (si_i),
        .level_o (si_s)
    );

    // ------------------------------------------------------------------
    // Serial shifter: counts bits, opcode first, then 24 address bits
    // ------------------------------------------------------------------
    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            sck_d_ff <= 1'b0;
            cs_d_ff  <= 1'b1;
            bits_ff  <= 6'd0;
            op_ff    <= 8'h00;
            addr_ff  <= 24'h000000;
        end
        else if (ce_i)
        begin
            sck_d_ff <= sck_s;
            cs_d_ff  <= cs_n_s;
            if (cs_fall)
                bits_ff <= 6'd0;
            else if (!cs_n_s && sck_rise)
            begin
                if (bits_ff != 6'd63)
                    bits_ff <= bits_ff + 6'd1;   // Saturates on long frames
                if (bits_ff < 6'd8)
                    op_ff <= op_done;
                else if (bits_ff < 6'd32)
                    addr_ff <= {addr_ff[22:0], si_s};
            end
        end
    end

    // ------------------------------------------------------------------
    // Frame decode on select rise; exact bit counts only
    // ------------------------------------------------------------------
    wire is_block = (op_ff == `OP_ERASE_4K) || (op_ff == `OP_ERASE_32K) || (op_ff == `OP_ERASE_64K);
    wire is_chip  = (op_ff == `OP_ERASE_CHIPA) || (op_ff == `OP_ERASE_CHIPB);
    wire frame8   = cs_rise && (bits_ff == 6'd8);
    wire frame32  = cs_rise && (bits_ff == 6'd32);
    wire take_blk = frame32 && is_block && write_enable_latch_o;
    wire take_chp = frame8 && is_chip && write_enable_latch_o;
    wire take_wren = frame8 && (op_ff == `OP_WREN);
    wire take_prog = prog_start_i && write_enable_latch_o;

    reg [2:0]  new_kind;
    reg [31:0] new_len;
    reg [23:0] new_mask;

    // Length and block mask for a newly accepted erase
    always @*
    begin
        new_kind = K_CHIP;
        new_len  = `WHOLE_ARRAY_ERASE_CYC;
        new_mask = 24'h000000;
        case (op_ff)
            `OP_ERASE_4K:
            begin
                new_kind = K_4K;
                new_len  = `SMALL_BLOCK_ERASE_CYC;
                new_mask = `MASK_4K;
            end
            `OP_ERASE_32K:
            begin
                new_kind = K_32K;
                new_len  = `MID_BLOCK_ERASE_CYC;
                new_mask = `MASK_32K;
            end
            `OP_ERASE_64K:
            begin
                new_kind = K_64K;
                new_len  = `LARGE_BLOCK_ERASE_CYC;
                new_mask = `MASK_64K;
            end
            default:
            begin
                new_kind = K_CHIP;
                new_len  = `WHOLE_ARRAY_ERASE_CYC;
                new_mask = 24'h000000;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Sequencer; power-on reset is the only reset, so pause state and
    // power-down are both lost on power loss
    // ------------------------------------------------------------------
    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            state_ff             <= ST_IDLE;
            kind_ff              <= K_NONE;
            remain_ff            <= 32'd0;
            tmr_ff               <= 32'd0;
            busy_o               <= 1'b0;
            write_enable_latch_o <= 1'b0;
            paused_op_flag_o     <= 1'b0;
            powered_down_o       <= 1'b0;
            erase_req_o          <= 1'b0;
            erase_addr_o         <= 24'h000000;
            erase_mask_o         <= 24'h000000;
            pdn_pend_ff          <= 1'b0;
            wake_pend_ff         <= 1'b0;
        end
        else if (ce_i)
        begin
            erase_req_o <= 1'b0;
            case (state_ff)
                ST_IDLE:
                begin
                    if (wake_pend_ff)
                    begin
                        // Waking: select must stay high for the delay
                        if (!cs_n_s)
                            tmr_ff <= `WAKE_RELEASE_CYC;
                        else if (tmr_ff != 32'd0)
                            tmr_ff <= tmr_ff - 32'd1;
                        else
                            wake_pend_ff <= 1'b0;
                    end
                    else if (pdn_pend_ff)
                    begin
                        if (tmr_ff != 32'd0)
                            tmr_ff <= tmr_ff - 32'd1;
                        else
                        begin
                            pdn_pend_ff    <= 1'b0;
                            powered_down_o <= 1'b1;
                            state_ff       <= ST_PDN;
                        end
                    end
                    else if (take_blk || take_chp)
                    begin
                        state_ff             <= ST_RUN;
                        kind_ff              <= new_kind;
                        remain_ff            <= new_len;
                        busy_o               <= 1'b1;
                        write_enable_latch_o <= 1'b0;
                        erase_req_o          <= 1'b1;
                        erase_mask_o         <= new_mask;
                        erase_addr_o         <= addr_ff & new_mask;
                    end
                    else if (take_prog)
                    begin
                        state_ff             <= ST_RUN;
                        kind_ff              <= K_PROG;
                        remain_ff            <= `PAGE_PROG_CYC;
                        busy_o               <= 1'b1;
                        write_enable_latch_o <= 1'b0;
                    end
                    else if (take_wren)
                        write_enable_latch_o <= 1'b1;
                    else if (frame8 && op_ff == `OP_PWRDN)
                    begin
                        pdn_pend_ff <= 1'b1;
                        tmr_ff      <= `POWERDOWN_ENTRY_CYC;
                    end
                    else if (frame8 && op_ff == `OP_RESUME && paused_op_flag_o)
                    begin
                        paused_op_flag_o <= 1'b0;
                        tmr_ff           <= `RESUME_BUSY_CYC;
                        state_ff         <= ST_RESW;
                    end
                end
                ST_RUN:
                begin
                    if (remain_ff <= 32'd1)
                    begin
                        busy_o   <= 1'b0;
                        kind_ff  <= K_NONE;
                        state_ff <= ST_IDLE;
                    end
                    else
                    begin
                        remain_ff <= remain_ff - 32'd1;
                        // Whole-array erase is not pausable
                        if (frame8 && op_ff == `OP_PAUSE && kind_ff != K_CHIP && !paused_op_flag_o)
                        begin
                            paused_op_flag_o <= 1'b1;
                            tmr_ff           <= `PAUSE_LATENCY_CYC;
                            state_ff         <= ST_PAUSEW;
                        end
                    end
                end
                ST_PAUSEW:
                begin
                    // Busy drops at the end of the pause latency
                    if (tmr_ff <= 32'd1)
                    begin
                        busy_o   <= 1'b0;
                        state_ff <= ST_PAUSED;
                    end
                    else
                        tmr_ff <= tmr_ff - 32'd1;
                end
                ST_PAUSED:
                begin
                    // Erases, writes and programs are the host's to avoid
                    if (frame8 && op_ff == `OP_RESUME)
                    begin
                        paused_op_flag_o <= 1'b0;
                        tmr_ff           <= `RESUME_BUSY_CYC;
                        state_ff         <= ST_RESW;
                    end
                    else if (take_wren)
                        write_enable_latch_o <= 1'b1;
                end
                ST_RESW:
                begin
                    if (kind_ff == K_NONE)
                    begin
                        // Nothing left to resume after power loss
                        tmr_ff   <= 32'd0;
                        state_ff <= ST_IDLE;
                    end
                    else if (tmr_ff <= 32'd1)
                    begin
                        busy_o   <= 1'b1;
                        state_ff <= ST_RUN;
                    end
                    else
                        tmr_ff <= tmr_ff - 32'd1;
                end
                ST_PDN:
                begin
                    // Only the release opcode is honoured here
                    if (frame8 && op_ff == `OP_WAKE)
                    begin
                        powered_down_o <= 1'b0;
                        wake_pend_ff   <= 1'b1;
                        tmr_ff         <= `WAKE_RELEASE_CYC;
                        state_ff       <= ST_IDLE;
                    end
                end
                default:
                begin
                    state_ff <= ST_IDLE;
                    busy_o   <= 1'b0;
                end
            endcase
        end
    end

endmodule

/* File: flash_host_model.sv */
/*
 * Behavioural serial host: mode 0 frames, opcode then address, MSB first.
 * Assumes an 800 ns serial clock with no phase tie to the core clock.
 */
module flash_host_model
(
    output logic cs_n_o,
    output logic sck_o,
    output logic si_o
);
timeunit 1ns;
timeprecision 1ns;

// Idle: deselected, serial clock parked low
initial
begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    si_o = 1'b0;
end

// ----------------------------------------------------------------------
// Frame tasks
// ----------------------------------------------------------------------
// Sends n bits from the top of w; odd offset keeps phase unrelated
task automatic shift_bits(input logic [31:0] w, input int n);
    int i;
    #37;
    cs_n_o = 1'b0;
    #400;
    for (i = 0; i < n; i++)
    begin
        si_o = w[31-i];
        #400;
        sck_o = 1'b1;
        #400;
        sck_o = 1'b0;
    end
    #400;
    cs_n_o = 1'b1;
    si_o = ~si_o;  // Released line must not keep its last value
    #1500;
endtask

task automatic op(input logic [7:0] code);
    shift_bits({code, 24'h000000}, 8);
endtask

task automatic op_addr(input logic [7:0] code, input logic [23:0] a);
    shift_bits({code, a}, 32);
endtask
endmodule

/* File: flash_seq_properties.sv */
/*
 * Port checker for the erase, pause and power-down sequencer.
 * Assumes it is bound to the sequencer top and sees one clock domain.
 */
module flash_seq_properties
(
    input wire        clk_i,
    input wire        nrst_i,
    input wire        ce_i,
    input wire        cs_n_i,
    input wire        sck_i,
    input wire        si_i,
    input wire        prog_start_i,
    input wire        busy_o,
    input wire        write_enable_latch_o,
    input wire        paused_op_flag_o,
    input wire        powered_down_o,
    input wire        erase_req_o,
    input wire [23:0] erase_addr_o,
    input wire [23:0] erase_mask_o,
    input wire [7:0]  erase_fill_o
);
// ----------------------------------------------------------------------
// Helper state
// ----------------------------------------------------------------------
reg chip_ff;
// Remembers a running whole-array erase, which must never pause
always @(posedge clk_i or negedge nrst_i)
begin
    if (!nrst_i)
        chip_ff <= 1'b0;
    else if (erase_req_o)
        chip_ff <= (erase_mask_o == 24'h000000);
    else if (!busy_o)
        chip_ff <= 1'b0;
end

default clocking cb @(posedge clk_i);
endclocking
default disable iff (!nrst_i);

// ----------------------------------------------------------------------
// Properties
// ----------------------------------------------------------------------
a_fill_all_ones: assert property (erase_fill_o == 8'hff)
    else $error("erase fill value is not all ones");
a_req_clears_wel: assert property (erase_req_o |-> busy_o && !write_enable_latch_o)
    else $error("erase start without busy set and latch cleared");
a_req_single_pulse: assert property (erase_req_o |=> !erase_req_o)
    else $error("erase start pulse longer than one cycle");
a_req_needs_wel: assert property (erase_req_o |-> $past(write_enable_latch_o))
    else $error("erase started with latch clear");
a_block_aligned: assert property (erase_req_o |-> (erase_addr_o & ~erase_mask_o) == 24'h000000
    && erase_mask_o inside {24'hfff000, 24'hff8000, 24'hff0000, 24'h000000})
    else $error("erase address not block aligned");
a_pause_when_busy: assert property ($rose(paused_op_flag_o) |-> $past(busy_o) && busy_o)
    else $error("pause flag rose while not busy");
a_pause_drops_busy: assert property ($rose(paused_op_flag_o) |-> ##[1:200] !busy_o)
    else $error("busy not cleared within pause latency");
a_no_chip_pause: assert property (chip_ff |-> !paused_op_flag_o)
    else $error("whole-array erase was paused");
a_resume_busy: assert property ($fell(paused_op_flag_o) |-> ##[0:2] busy_o)
    else $error("busy not set soon after resume");
a_pd_frozen: assert property (powered_down_o && $past(powered_down_o)
    |-> !erase_req_o && $stable(write_enable_latch_o))
    else $error("state changed in deep power-down");
a_frozen_off_ce: assert property (!$past(ce_i) |-> $stable(busy_o) && $stable(write_enable_latch_o)
    && $stable(paused_op_flag_o) && $stable(powered_down_o))
    else $error("state moved while clock enable low");

c_erase: cover property (erase_req_o);
c_pause: cover property ($rose(paused_op_flag_o));
c_powerdown: cover property ($rose(powered_down_o));
c_program: cover property (prog_start_i && !busy_o);
endmodule

bind flash_erase_suspend_powerdown flash_seq_properties u_props
(
    .clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .cs_n_i(cs_n_i), .sck_i(sck_i), .si_i(si_i),
    .prog_start_i(prog_start_i), .busy_o(busy_o), .write_enable_latch_o(write_enable_latch_o),
    .paused_op_flag_o(paused_op_flag_o), .powered_down_o(powered_down_o), .erase_req_o(erase_req_o),
    .erase_addr_o(erase_addr_o), .erase_mask_o(erase_mask_o), .erase_fill_o(erase_fill_o)
);

/* File: flash_seq_regs.vh */
/*
 * Constants for the erase, pause and power-down sequencer: opcodes,
 * block address masks and self-timed durations in clock cycles.
 * Assumes a 10 MHz core clock (100 ns period) and is included by name.
 */
`ifndef FLASH_SEQ_REGS_VH
`define FLASH_SEQ_REGS_VH

// ----------------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------------
`define OP_WREN        8'h06
`define OP_ERASE_4K    8'h20
`define OP_ERASE_32K   8'h52
`define OP_ERASE_64K   8'hd8
`define OP_ERASE_CHIPA 8'hc7
`define OP_ERASE_CHIPB 8'h60
`define OP_PROG        8'h02
`define OP_QPROG       8'h33
`define OP_WRSR1       8'h01
`define OP_WRSR2       8'h31
`define OP_PAUSE       8'h75
`define OP_RESUME      8'h7a
`define OP_PWRDN       8'hb9
`define OP_WAKE        8'hab

// ----------------------------------------------------------------------
// Block address masks (low bits cleared) and erase fill value
// ----------------------------------------------------------------------
`define MASK_4K        24'hfff000
`define MASK_32K       24'hff8000
`define MASK_64K       24'hff0000
`define ERASED_BYTE    8'hff

// ----------------------------------------------------------------------
// Timing: times in ns, counts derived for 100 ns clock
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS             100
`define RESUME_BUSY_NS            200
`define RESUME_BUSY_CYC           (`RESUME_BUSY_NS / `CLK_PERIOD_NS)
`define SMALL_BLOCK_ERASE_CYC     600000
`define MID_BLOCK_ERASE_CYC       2000000
`define LARGE_BLOCK_ERASE_CYC     3500000
`define WHOLE_ARRAY_ERASE_CYC     32'd400000000
`define PAGE_PROG_CYC             6000
`define PAUSE_LATENCY_NS          20000
`define PAUSE_LATENCY_CYC         (`PAUSE_LATENCY_NS / `CLK_PERIOD_NS)
`define POWERDOWN_ENTRY_NS        3000
`define POWERDOWN_ENTRY_CYC       ((`POWERDOWN_ENTRY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WAKE_RELEASE_NS           3000
`define WAKE_RELEASE_CYC          ((`WAKE_RELEASE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* File: pin_sync3.v */
/*
 * Three-stage synchroniser with agreement filter for one pin input.
 * Assumes the pin is asynchronous to clk_i; output changes only when
 * the second and third stages agree.
 */
module pin_sync3
#(
    parameter RESET_VAL = 1'b0
)
(
    input  wire clk_i,
    input  wire nrst_i,
    input  wire ce_i,
    input  wire pin_i,
    output wire level_o
);

    reg s1_ff;
    reg s2_ff;
    reg s3_ff;
    reg lvl_ff;

    // ------------------------------------------------------------------
    // Sync chain: first stage feeds only the second
    // ------------------------------------------------------------------
    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            s1_ff  <= RESET_VAL;
            s2_ff  <= RESET_VAL;
            s3_ff  <= RESET_VAL;
            lvl_ff <= RESET_VAL;
        end
        else if (ce_i)
        begin
            s1_ff <= pin_i;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            if (s2_ff == s3_ff)
                lvl_ff <= s3_ff;   // Accept only agreed value
        end
    end

    assign level_o = lvl_ff;

endmodule

/* File: tb_flash_erase_suspend_powerdown.sv */
/*
 * Self-checking bench for the erase, pause and power-down sequencer.
 * Assumes the host model drives the serial pins and self-timed counts
 * are the fixed header values, so long erases are ended by power loss.
 */
module tb_flash_erase_suspend_powerdown;
timeunit 1ns;
timeprecision 1ns;

logic        clk_i = 1'b0;
logic        nrst_i = 1'b0;
logic        prog_start_i = 1'b0;
logic        ce_i = 1'b1;
wire         cs_n, sck, si, busy, latch, paused, pd, req;
wire  [23:0] addr, mask;
wire  [7:0]  fill;
int          mismatches = 0;
int          total_checks = 0;
int          cycles = 0;
int          req_cnt = 0;
logic [23:0] req_addr, req_mask;

always #50 clk_i = ~clk_i;

flash_host_model host (.cs_n_o(cs_n), .sck_o(sck), .si_o(si));

flash_erase_suspend_powerdown uut
(
    .clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .cs_n_i(cs_n), .sck_i(sck), .si_i(si),
    .prog_start_i(prog_start_i), .busy_o(busy), .write_enable_latch_o(latch),
    .paused_op_flag_o(paused), .powered_down_o(pd), .erase_req_o(req),
    .erase_addr_o(addr), .erase_mask_o(mask), .erase_fill_o(fill)
);

// ----------------------------------------------------------------------
// Monitors and helpers
// ----------------------------------------------------------------------
// Erase starts captured mid-cycle, clear of the launching edge
always @(negedge clk_i)
begin
    if (req === 1'b1)
    begin
        req_cnt++;
        req_addr = addr;
        req_mask = mask;
    end
end

// Hang guard: the whole run needs well under this many cycles
always @(posedge clk_i)
begin
    cycles++;
    if (cycles == 60000)
    begin
        mismatches++;
        tally_and_finish();
    end
end

task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    total_checks++;
    if (got !== exp)
    begin
        mismatches++;
        $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
endtask

// Power loss: the only way to end a long self-timed erase here
task automatic power_cycle();
    @(posedge clk_i);
    nrst_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
endtask

// ----------------------------------------------------------------------
// Scenarios
// ----------------------------------------------------------------------
task automatic t_power_on();
    chk("busy", 0, busy);
    chk("powered down", 0, pd);
    chk("pause flag", 0, paused);
    chk("fill", 24'h0000ff, fill);
    host.op_addr(8'h20, 24'h001234);
    chk("erase without latch", 0, req_cnt);
endtask

task automatic t_block(input logic [7:0] code, input logic [23:0] m);
    int n;
    n = req_cnt;
    host.op(8'h06);
    chk("latch", 1, latch);
    host.op_addr(code, 24'habcdef);
    chk("erase starts", n + 1, req_cnt);
    chk("busy", 1, busy);
    chk("latch after start", 0, latch);
    chk("erase mask", m, req_mask);
    chk("erase base", 24'habcdef & m, req_addr);
    power_cycle();
endtask

task automatic t_chip(input logic [7:0] code);
    host.op(8'h06);
    host.op(code);
    chk("chip mask", 0, req_mask);
    chk("busy", 1, busy);
    host.op(8'h75);
    chk("chip pause", 0, paused);
    power_cycle();
endtask

// Select rising one bit early, and a late power-down select
task automatic t_bad_frames();
    int n;
    n = req_cnt;
    host.op(8'h06);
    host.shift_bits({8'h20, 24'h004000}, 31);
    chk("short frame erase", n, req_cnt);
    host.shift_bits({8'hb9, 24'h000000}, 9);
    repeat (40) @(posedge clk_i);
    chk("late select power-down", 0, pd);
    power_cycle();
endtask

task automatic t_pause_resume();
    host.op(8'h7a);
    chk("idle resume", 0, busy);
    host.op(8'h75);
    chk("idle pause", 0, paused);
    host.op(8'h06);
    host.op_addr(8'h52, 24'h018000);
    host.op(8'h75);
    chk("pause flag", 1, paused);
    repeat (200) @(posedge clk_i);
    chk("busy after pause", 0, busy);
    host.op(8'h75);
    chk("second pause", 1, paused);
    host.op(8'h7a);
    chk("resume flag", 0, paused);
    chk("resume busy", 1, busy);
    host.op(8'h7a);
    chk("resume while busy", 1, busy);
    repeat (200) @(posedge clk_i);
    host.op(8'h75);
    chk("pause again", 1, paused);
    power_cycle();
    chk("flag after power loss", 0, paused);
    host.op(8'h7a);
    chk("resume after power loss", 0, busy);
endtask

task automatic t_program();
    int i;
    int n;
    host.op(8'h06);
    @(posedge clk_i);
    prog_start_i <= 1'b1;
    @(posedge clk_i);
    prog_start_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("program busy", 1, busy);
    chk("program latch", 0, latch);
    // Clock enable low for 1000 cycles stretches the cycle by as much
    ce_i <= 1'b0;
    repeat (1000) @(posedge clk_i);
    chk("busy while frozen", 1, busy);
    ce_i <= 1'b1;
    n = 1003;
    while (n < 9000)
    begin
        @(negedge clk_i);
        if (busy !== 1'b1)
            break;
        n++;
    end
    chk("program length", 6000 + 1000, n);
    chk("busy at end", 0, busy);
    // A paused program resumes and runs to its end
    host.op(8'h06);
    @(posedge clk_i);
    prog_start_i <= 1'b1;
    @(posedge clk_i);
    prog_start_i <= 1'b0;
    host.op(8'h75);
    chk("program pause", 1, paused);
    repeat (210) @(posedge clk_i);
    chk("program paused busy", 0, busy);
    host.op(8'h7a);
    chk("program resume busy", 1, busy);
    for (i = 0; i < 7000 && busy !== 1'b0; i++)
        @(posedge clk_i);
    chk("resumed program ends", 0, busy);
endtask

task automatic t_powerdown();
    host.op(8'hb9);
    repeat (40) @(posedge clk_i);
    chk("powered down", 1, pd);
    host.op(8'h06);
    chk("latch in power-down", 0, latch);
    host.op(8'hab);
    chk("woken", 0, pd);
    repeat (40) @(posedge clk_i);
    host.op(8'h06);
    chk("latch after wake", 1, latch);
    host.op(8'hb9);
    repeat (40) @(posedge clk_i);
    power_cycle();
    chk("standby after power-up", 0, pd);
endtask

// ----------------------------------------------------------------------
// Main sequence and verdict
// ----------------------------------------------------------------------
task automatic tally_and_finish();
    if (mismatches == 0 && total_checks > 0)
        $display("verification passed");
    else
        $display("verification failed");
    $finish;
endtask

initial
begin
    repeat (20) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    t_power_on();
    t_block(8'h20, 24'hfff000);
    t_block(8'h52, 24'hff8000);
    t_block(8'hd8, 24'hff0000);
    t_chip(8'hc7);
    t_chip(8'h60);
    t_bad_frames();
    t_pause_resume();
    t_program();
    t_powerdown();
    tally_and_finish();
end
endmodule
